// ==== pkg/dtr_pkg.sv ====
// shared constants and types for the data tenure retry controller
package dtr_pkg;
    localparam int          QUEUE_DEPTH  = 3;
    localparam logic [2:0]  BURST_BEATS  = 3'h4;
    localparam logic [2:0]  SINGLE_BEATS = 3'h1;
    localparam logic [3:0]  WIN_MIN      = 4'h2;
    localparam logic [3:0]  TS_CNT_MAX   = 4'hF;
    localparam logic [1:0]  CNT_ZERO     = 2'h0;

    typedef struct packed {
        logic write;
        logic burst;
    } dtr_entry_s;

    typedef struct packed {
        logic       streaming_mode;
        logic [3:0] snoop_win_start;
    } dtr_cfg_s;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_GRANT = 2'b01,
        ST_DATA  = 2'b10,
        ST_GAP   = 2'b11
    } dtr_state_e;
endpackage

// ==== rtl/dtr_queue.sv ====
// ordered queue of pending data tenures, removal at any slot
`timescale 1ns/1ps
`default_nettype none
module dtr_queue (
    input  wire logic                    clk_i,
    input  wire logic                    rst_b_i,
    input  wire logic                    push_i,
    input  wire dtr_pkg::dtr_entry_s     push_data_i,
    input  wire logic [2:0]              pop_mask_i,
    output dtr_pkg::dtr_entry_s          entry_o [3],
    output logic [1:0]                   count_o
);
    dtr_pkg::dtr_entry_s q_r   [3];
    dtr_pkg::dtr_entry_s q_nxt [3];
    logic [1:0]          cnt_r;
    logic [1:0]          cnt_nxt;

    // compaction keeps address order among the survivors
    always_comb begin
        logic [1:0] k;
        k = 2'h0;
        for (int i = 0; i < 3; i++) begin
            q_nxt[i] = '0;
        end
        for (int i = 0; i < 3; i++) begin
            if ((2'(i) < cnt_r) && !pop_mask_i[i]) begin
                q_nxt[k] = q_r[i];
                k = k + 2'h1;
            end
        end
        // a fourth pending tenure cannot occur, so a push when full is dropped
        if (push_i && (k < 2'h3)) begin
            q_nxt[k] = push_data_i;
            k = k + 2'h1;
        end
        cnt_nxt = k;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= dtr_pkg::CNT_ZERO;
            for (int i = 0; i < 3; i++) begin
                q_r[i] <= '0;
            end
        end else begin
            cnt_r <= cnt_nxt;
            q_r   <= q_nxt;
        end
    end

    assign entry_o = q_r;
    assign count_o = cnt_r;
endmodule
`default_nettype wire

// ==== rtl/dtr_host.sv ====
// system-side data bus arbiter and acknowledge generator facing the processor
// Overview of operation
// - acknowledge no earlier than one cycle (normal) or zero cycles before window start.
// - in streaming mode, first data no earlier than the retry window's first cycle.
// - early acknowledge closes window that clock (streaming) or next clock (normal).
// - never acknowledge so early that an address retry could not cancel it.
// - retry cancels data acknowledged just before window; tenure aborted, not extended.
// - after grant and retry, processor drops busy; no further data is sent.
// - retry of a later tenure leaves earlier tenures' data untouched.
// - retry before grant cancels that tenure; never grant it afterwards.
// - normal mode without busy: grant only the cycle before tenure may start.
// - use write-only only to move a burst write ahead of a read.
`timescale 1ns/1ps
`default_nettype none
module dtr_host (
    input  wire logic                clk_i,
    input  wire logic                rst_b_i,
    input  wire dtr_pkg::dtr_cfg_s   cfg_i,
    input  wire logic                transfer_start_strobe_i,
    input  wire dtr_pkg::dtr_entry_s transfer_type_i,
    input  wire logic                needs_data_i,
    input  wire logic                address_ack_i,
    input  wire logic                address_retry_i,
    input  wire logic                data_bus_busy_i,
    input  wire logic                mem_ready_i,
    input  wire logic                reorder_req_i,
    output logic                     data_bus_grant_o,
    output logic                     write_only_reorder_o,
    output logic                     transfer_acknowledge_o,
    output logic                     data_retry_o,
    output logic                     tenure_done_o,
    output logic                     tenure_aborted_o,
    output logic [1:0]               pending_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    dtr_pkg::dtr_state_e state_r, state_nxt;
    dtr_pkg::dtr_entry_s entry [3];
    logic [1:0]          count;
    logic [1:0]          cur_r, cur_nxt;
    logic [2:0]          beats_r, beats_nxt;
    logic [3:0]          ts_cnt_r;
    logic                live_r, live_data_r, aack_d_r, ta_d_r;
    logic                grant_r, wo_r, ta_r, done_r, abort_r;
    logic [1:0]          pending_r;
    logic                grant_nxt, wo_nxt, ta_nxt;

    function automatic logic [1:0] oldest_write(input dtr_pkg::dtr_entry_s e [3], input logic [1:0] n);
        logic [1:0] idx;
        idx = 2'h3;
        for (int i = 2; i >= 0; i--) begin
            if ((2'(i) < n) && e[i].write) begin
                idx = 2'(i);
            end
        end
        return idx;
    endfunction

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic       stream    = cfg_i.streaming_mode;
    wire logic [1:0] tail      = count - 2'h1;
    wire logic [1:0] wr_idx    = oldest_write(entry, count);
    wire logic       promote   = reorder_req_i && (wr_idx != 2'h3) && (wr_idx != 2'h0) && entry[wr_idx].burst;
    wire logic [1:0] pick_idx  = promote ? wr_idx : 2'h0;
    // retry only hits the newest, still live tenure
    wire logic       retry_hit = address_retry_i && live_r && live_data_r && (count != dtr_pkg::CNT_ZERO);
    wire logic       cur_live  = live_r && live_data_r && (cur_r == tail);
    wire logic       cur_hit   = retry_hit && (cur_r == tail);
    // earliest acknowledge cycle relative to the start strobe
    wire logic [3:0] ta_thr    = stream ? cfg_i.snoop_win_start : cfg_i.snoop_win_start - 4'h1;
    // counter lags the strobe by one and the ack lands a cycle later, hence a lead of two
    wire logic       ta_ok     = !cur_live || (({1'b0, ts_cnt_r} + 5'h02) >= {1'b0, ta_thr});
    wire logic       last_beat = ta_r && (beats_r == 3'h1);
    wire logic       win_close = aack_d_r || (stream ? (ta_r && cur_live) : ta_d_r);
    // processor busy gates grants outside streaming mode
    wire logic       bus_free  = stream || !data_bus_busy_i;
    wire logic       can_grant = (count != dtr_pkg::CNT_ZERO) && bus_free && !retry_hit;
    wire logic       pop_cur   = ((state_r == dtr_pkg::ST_GRANT) || (state_r == dtr_pkg::ST_DATA))
                                 && !cur_hit && (state_r == dtr_pkg::ST_DATA) && last_beat;
    // retry before grant drops the implied request
    wire logic [2:0] pop_mask  = (retry_hit ? (3'h1 << tail) : 3'h0) | (pop_cur ? (3'h1 << cur_r) : 3'h0);
    wire logic       push      = transfer_start_strobe_i && needs_data_i;

    dtr_queue u_queue (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .push_i      (push),
        .push_data_i (transfer_type_i),
        .pop_mask_i  (pop_mask),
        .entry_o     (entry),
        .count_o     (count)
    );

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cur_nxt   = cur_r;
        beats_nxt = beats_r;
        grant_nxt = 1'b0;
        wo_nxt    = 1'b0;
        ta_nxt    = 1'b0;
        unique case (state_r)
            dtr_pkg::ST_IDLE: begin
                // grant raised only when the tenure may start next cycle
                if (can_grant) begin
                    grant_nxt = 1'b1;
                    wo_nxt    = promote;
                    cur_nxt   = pick_idx;
                    beats_nxt = entry[pick_idx].burst ? dtr_pkg::BURST_BEATS : dtr_pkg::SINGLE_BEATS;
                    state_nxt = dtr_pkg::ST_GRANT;
                end
            end
            dtr_pkg::ST_GRANT: begin
                if (cur_hit) begin
                    state_nxt = dtr_pkg::ST_IDLE;
                end else begin
                    ta_nxt    = mem_ready_i && ta_ok;
                    state_nxt = dtr_pkg::ST_DATA;
                end
            end
            dtr_pkg::ST_DATA: begin
                if (ta_r) begin
                    beats_nxt = beats_r - 3'h1;
                end
                // no data after retry; burst cut short
                if (cur_hit || last_beat) begin
                    state_nxt = stream ? dtr_pkg::ST_IDLE : dtr_pkg::ST_GAP;
                end else begin
                    ta_nxt = mem_ready_i && ta_ok;
                end
                if (cur_hit) begin
                    ta_nxt = 1'b0;
                end
            end
            dtr_pkg::ST_GAP: begin
                // one idle cycle while the processor drops busy
                state_nxt = dtr_pkg::ST_IDLE;
            end
        endcase
        // keep the current slot index valid when an older slot is removed
        if (retry_hit && !cur_hit && (tail < cur_r)) begin
            cur_nxt = cur_r - 2'h1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_r <= dtr_pkg::ST_IDLE;
            cur_r   <= 2'h0;
            beats_r <= 3'h0;
            grant_r <= 1'b0;
            wo_r    <= 1'b0;
            ta_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cur_r   <= cur_nxt;
            beats_r <= beats_nxt;
            grant_r <= grant_nxt;
            wo_r    <= wo_nxt;
            ta_r    <= ta_nxt;
        end
    end

    // ------------------------------------------------------------
    // snoop window tracking
    // ------------------------------------------------------------
    // window start is a static input, at least two cycles
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            live_r      <= 1'b0;
            live_data_r <= 1'b0;
            ts_cnt_r    <= 4'h0;
            aack_d_r    <= 1'b0;
            ta_d_r      <= 1'b0;
        end else begin
            aack_d_r <= address_ack_i && live_r;
            ta_d_r   <= ta_r && cur_live && !stream;
            if (transfer_start_strobe_i) begin
                live_r      <= 1'b1;
                live_data_r <= needs_data_i;
                ts_cnt_r    <= 4'h0;
            end else begin
                if (ts_cnt_r != dtr_pkg::TS_CNT_MAX) begin
                    ts_cnt_r <= ts_cnt_r + 4'h1;
                end
                // retry within the window cancels; afterwards it cannot
                if (win_close || retry_hit) begin
                    live_r <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // status
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_r    <= 1'b0;
            abort_r   <= 1'b0;
            pending_r <= 2'h0;
        end else begin
            done_r    <= pop_cur;
            // acknowledged data in window is voided by the abort
            abort_r   <= cur_hit && ((state_r == dtr_pkg::ST_GRANT) || (state_r == dtr_pkg::ST_DATA));
            pending_r <= count;
        end
    end

    assign data_bus_grant_o       = grant_r;
    assign write_only_reorder_o   = wo_r;
    assign transfer_acknowledge_o = ta_r;
    // data retry is never used by this controller
    assign data_retry_o           = 1'b0;
    assign tenure_done_o          = done_r;
    assign tenure_aborted_o       = abort_r;
    assign pending_o              = pending_r;
endmodule
`default_nettype wire

// ==== bench/dtr_host_asserts.sv ====
// assertion checker bound to the data tenure controller
`timescale 1ns/1ps
`default_nettype none
module dtr_host_asserts (
    input wire logic              clk_i,
    input wire logic              rst_b_i,
    input wire dtr_pkg::dtr_cfg_s cfg_i,
    input wire logic              data_bus_busy_i,
    input wire logic              data_bus_grant_o,
    input wire logic              write_only_reorder_o,
    input wire logic              transfer_acknowledge_o,
    input wire logic              data_retry_o,
    input wire logic              tenure_done_o,
    input wire logic              tenure_aborted_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // ----------------------------------------
    // grant and beat relations
    // ----------------------------------------
    sequence s_no_ack2;
        !transfer_acknowledge_o [*2];
    endsequence
    sequence s_no_grant2;
        !data_bus_grant_o ##1 !data_bus_grant_o;
    endsequence
    a_grant_one_pulse: assert property (data_bus_grant_o |=> !data_bus_grant_o)
        else $error("grant held longer than one cycle");
    a_reorder_with_grant: assert property (write_only_reorder_o |-> data_bus_grant_o)
        else $error("write only without grant");
    a_abort_stops_ack: assert property (tenure_aborted_o |-> s_no_ack2)
        else $error("beat acknowledged after abort");
    a_done_after_beat: assert property (tenure_done_o |-> $past(transfer_acknowledge_o) && !tenure_aborted_o)
        else $error("done without a final beat");
    a_grant_after_idle: assert property (!cfg_i.streaming_mode && data_bus_grant_o |-> !$past(data_bus_busy_i))
        else $error("grant decided while processor busy");
    a_gap_after_done: assert property (!cfg_i.streaming_mode && tenure_done_o |-> s_no_grant2)
        else $error("grant too soon after tenure end");
    a_ack_in_tenure: assert property (transfer_acknowledge_o |-> data_bus_busy_i)
        else $error("beat acknowledged outside a tenure");
    a_data_retry_idle: assert property (!data_retry_o)
        else $error("data retry driven");
endmodule
bind dtr_host dtr_host_asserts u_chk (.clk_i, .rst_b_i, .cfg_i, .data_bus_busy_i, .data_bus_grant_o,
    .write_only_reorder_o, .transfer_acknowledge_o, .data_retry_o, .tenure_done_o, .tenure_aborted_o);
`default_nettype wire

// ==== bench/dtr_cpu_model.sv ====
// behavioural processor side: pending tenures, busy and beat counting
`timescale 1ns/1ps
`default_nettype none
module dtr_cpu_model (
    input  wire logic                clk_i,
    input  wire logic                rst_b_i,
    input  wire dtr_pkg::dtr_cfg_s   cfg_i,
    input  wire logic                transfer_start_strobe_i,
    input  wire dtr_pkg::dtr_entry_s transfer_type_i,
    input  wire logic                needs_data_i,
    input  wire logic                address_retry_i,
    input  wire logic                data_bus_grant_i,
    input  wire logic                write_only_reorder_i,
    input  wire logic                transfer_acknowledge_i,
    output logic                     data_bus_busy_o
);
    dtr_pkg::dtr_entry_s q [$];
    int                  beats;
    int                  pick;
    logic                retry_d;
    // window position is static config, any start from two accepted
    // own busy gates the grant outside streaming mode
    wire qual = data_bus_grant_i && !address_retry_i && (cfg_i.streaming_mode || !data_bus_busy_o);
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q.delete();
            beats = 0;
            retry_d <= 1'b0;
            data_bus_busy_o <= 1'b0;
        end else begin
            retry_d <= address_retry_i;
            // retry ends the active tenure, busy drops next cycle
            if (beats > 0 && address_retry_i) begin
                beats = 0;
                data_bus_busy_o <= 1'b0;
            end else if (beats > 0 && transfer_acknowledge_i) begin
                beats = beats - 1;
                data_bus_busy_o <= beats > 0;
            // retry cancels the newest tenure, also a coincident grant
            end else if (address_retry_i && !retry_d && q.size() > 0) begin
                void'(q.pop_back());
            // oldest write on reorder, else the head
            end else if (qual && beats == 0 && q.size() > 0) begin
                pick = 0;
                for (int i = q.size() - 1; i > 0; i--) begin
                    if (write_only_reorder_i && q[i].write && !q[0].write)
                        pick = i;
                end
                beats = q[pick].burst ? int'(dtr_pkg::BURST_BEATS) : int'(dtr_pkg::SINGLE_BEATS);
                q.delete(pick);
                data_bus_busy_o <= 1'b1;
            end
            // up to three tenures wait for a grant
            if (transfer_start_strobe_i && needs_data_i && q.size() < dtr_pkg::QUEUE_DEPTH)
                q.push_back(transfer_type_i);
        end
    end
endmodule
`default_nettype wire

// ==== bench/test_dtr_host.sv ====
// self-checking bench for the data tenure controller
`timescale 1ns/1ps
`default_nettype none
module test_dtr_host;
    logic                clk_i, rst_b_i, transfer_start_strobe_i, needs_data_i, address_ack_i;
    logic                address_retry_i, data_bus_busy_i, mem_ready_i, reorder_req_i;
    logic                data_bus_grant_o, write_only_reorder_o, transfer_acknowledge_o;
    logic                data_retry_o, tenure_done_o, tenure_aborted_o;
    logic [1:0]          pending_o;
    dtr_pkg::dtr_cfg_s   cfg_i;
    dtr_pkg::dtr_entry_s transfer_type_i;
    int                  bad_count, n_compared, cyc, nxt, acks, dones, aborts, first, aack_at, r_from, r_to;
    logic                glog [$];
    dtr_host DUT (.clk_i, .rst_b_i, .cfg_i, .transfer_start_strobe_i, .transfer_type_i, .needs_data_i,
        .address_ack_i, .address_retry_i, .data_bus_busy_i, .mem_ready_i, .reorder_req_i, .data_bus_grant_o,
        .write_only_reorder_o, .transfer_acknowledge_o, .data_retry_o, .tenure_done_o, .tenure_aborted_o, .pending_o);
    dtr_cpu_model u_cpu (.clk_i, .rst_b_i, .cfg_i, .transfer_start_strobe_i, .transfer_type_i, .needs_data_i,
        .address_retry_i, .data_bus_grant_i(data_bus_grant_o), .write_only_reorder_i(write_only_reorder_o),
        .transfer_acknowledge_i(transfer_acknowledge_o), .data_bus_busy_o(data_bus_busy_i));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // address acknowledge and retry are placed in cycles counted from the strobe
    always @(posedge clk_i) begin
        nxt = transfer_start_strobe_i ? 1 : cyc + 1;
        cyc <= nxt;
        address_ack_i <= nxt == aack_at;
        address_retry_i <= nxt >= r_from && nxt <= r_to;
        if (transfer_acknowledge_o === 1'b1 && first < 0)
            first = cyc;
        acks += int'(transfer_acknowledge_o === 1'b1);
        dones += int'(tenure_done_o === 1'b1);
        aborts += int'(tenure_aborted_o === 1'b1);
        if (data_bus_grant_o === 1'b1)
            glog.push_back(write_only_reorder_o);
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic report_and_stop();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        while (tenure_done_o !== 1'b1 && n < 300) begin
            @(negedge clk_i);
            n++;
        end
        @(negedge clk_i);
        if (n >= 300) begin
            bad_count++;
            report_and_stop();
        end
    endtask
    task automatic setup(input logic mode, input int win, input int aack, input int rf, input int rt);
        @(posedge clk_i);
        cfg_i <= '{streaming_mode: mode, snoop_win_start: 4'(win)};
        reorder_req_i <= 1'b0;
        aack_at = aack;
        r_from = rf;
        r_to = rt;
        acks = 0;
        dones = 0;
        aborts = 0;
        first = -1;
        glog.delete();
    endtask
    task automatic start_xfer(input logic wr, input logic bu);
        @(posedge clk_i);
        transfer_start_strobe_i <= 1'b1;
        needs_data_i <= 1'b1;
        transfer_type_i <= '{write: wr, burst: bu};
        @(posedge clk_i);
        transfer_start_strobe_i <= 1'b0;
        needs_data_i <= 1'b0;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_single(input logic mode, input int win);
        setup(mode, win, win, 1000, 0);
        start_xfer(1'b1, 1'b0);
        wait_done();
        check("single_acks", 8'(acks), 8'h01);
        check("first_ack_cycle", 8'(first), 8'((win - 1 + int'(mode) > 3) ? win - 1 + int'(mode) : 3));
        check("data_retry", 8'(data_retry_o), 8'h00);
    endtask
    task automatic t_retry(input int win, input int aack, input int rf, input int rt, input logic bu, input int ak,
                           input int ab);
        setup(1'b0, win, aack, rf, rt);
        start_xfer(1'b0, bu);
        repeat (30) @(negedge clk_i);
        check("beats_after_retry", 8'(acks), 8'(ak));
        check("done_after_retry", 8'(dones), 8'h00);
        check("aborts", 8'(aborts), 8'(ab));
        check("pending_after_retry", 8'(pending_o), 8'h00);
    endtask
    task automatic t_reorder();
        setup(1'b0, 2, 2, 1000, 0);
        mem_ready_i <= 1'b0;
        start_xfer(1'b0, 1'b1);
        start_xfer(1'b0, 1'b0);
        start_xfer(1'b1, 1'b1);
        reorder_req_i <= 1'b1;
        mem_ready_i <= 1'b1;
        repeat (3) wait_done();
        check("grants", 8'(glog.size()), 8'h03);
        foreach (glog[i])
            check("write_only", 8'(glog[i]), 8'(i == 1));
    endtask
    initial begin
        {rst_b_i, transfer_start_strobe_i, needs_data_i, address_ack_i, address_retry_i, reorder_req_i} = '0;
        bad_count = 0;
        n_compared = 0;
        cyc = 0;
        aack_at = 1000;
        r_from = 1000;
        r_to = 0;
        mem_ready_i = 1'b1;
        cfg_i = '{streaming_mode: 1'b0, snoop_win_start: 4'h2};
        transfer_type_i = '{write: 1'b0, burst: 1'b0};
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_single(1'b0, 6);
        t_single(1'b1, 4);
        t_single(1'b0, 2);
        t_retry(2, 3, 1, 4, 1'b1, 0, 0);
        // a retry in the grant cycle disqualifies the grant and is reported as an abort
        t_retry(2, 1, 2, 2, 1'b0, 0, 1);
        t_retry(2, 3, 3, 4, 1'b1, 1, 1);
        // first beat acknowledged the cycle before the window, retry in its first cycle
        t_retry(4, 5, 4, 5, 1'b1, 2, 1);
        t_reorder();
        report_and_stop();
    end
endmodule
`default_nettype wire
